// File: sim/adcb_ctrl_checker.sv
// Purpose: Port-level checks of the converter accumulator control.
// Assumes: One clock domain; srst is synchronous and active high.
// Notes:   Bound to every adcb_ctrl instance at the foot of this file.
`timescale 1ns/10ps
`include "adcb_map.vh"

module adcb_ctrl_checker
(
	// Clock and reset
	input wire        clk,
	input wire        srst,
	// SFR access
	input wire [7:0]  sfr_addr,
	input wire [7:0]  sfr_page,
	input wire        sfr_wr,
	input wire        sfr_rd,
	input wire [7:0]  sfr_wdata,
	input wire [7:0]  sfr_rdata,
	// Loose control bits
	input wire        converter_enable,
	input wire        burst_mode_enable,
	input wire        soc_pulse,
	input wire        complete_clear,
	// SAR handshake and status
	input wire        conv_done,
	input wire [11:0] conv_data,
	input wire        conv_start,
	input wire        twelve_bit_enable,
	input wire        low_power_mode_enable,
	input wire        sar_powered,
	input wire        conv_complete,
	input wire        busy
);
	// Both registers share one address; only the page tells them apart.
	wire cfg_wr = sfr_wr && sfr_addr == `ADCB_ADDR_ACC_CFG
		&& sfr_page == `ADCB_PAGE_ACC_CFG;
	wire pwr_wr = sfr_wr && sfr_addr == `ADCB_ADDR_PWR_TIME
		&& sfr_page == `ADCB_PAGE_PWR_TIME;
	wire idle_soc = soc_pulse && !busy;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_twelve_follows:
	assert property (cfg_wr ##1 !cfg_wr |=>
		twelve_bit_enable == $past(sfr_wdata[7], 2))
		else $error("twelve-bit mode differs from written bit");
	a_lowpow_follows:
	assert property (pwr_wr ##1 !pwr_wr |=>
		low_power_mode_enable == $past(sfr_wdata[7], 2))
		else $error("low power mode differs from written bit");
	a_power_by_enable:
	assert property (!burst_mode_enable && $past(!burst_mode_enable)
		&& $stable(converter_enable) |-> sar_powered == converter_enable)
		else $error("power request does not follow main enable");
	a_idle_soc_ignored:
	assert property (idle_soc && !burst_mode_enable && !converter_enable
		|=> !conv_start && !busy)
		else $error("start accepted while converter disabled");
	a_burst_immediate:
	assert property (idle_soc && burst_mode_enable && converter_enable
		|=> conv_start)
		else $error("enabled burst did not start at once");
	a_burst_stays_on:
	assert property (burst_mode_enable && converter_enable
		&& $past(burst_mode_enable) && $past(converter_enable)
		|-> sar_powered)
		else $error("enabled burst dropped power");
	a_burst_waits:
	assert property (idle_soc && burst_mode_enable && !converter_enable
		|=> !conv_start [*8])
		else $error("sleeping burst started without power-up delay");
	a_complete_single:
	assert property (conv_done && busy && !burst_mode_enable
		|-> ##2 conv_complete)
		else $error("complete flag late after single conversion");
	a_complete_sticky:
	assert property (conv_complete && !complete_clear |=> conv_complete)
		else $error("complete flag dropped without clear");
endmodule // adcb_ctrl_checker

bind adcb_ctrl adcb_ctrl_checker u_adcb_ctrl_checker (.clk(clk),
	.srst(srst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .converter_enable(converter_enable),
	.burst_mode_enable(burst_mode_enable), .soc_pulse(soc_pulse),
	.complete_clear(complete_clear), .conv_done(conv_done),
	.conv_data(conv_data), .conv_start(conv_start),
	.twelve_bit_enable(twelve_bit_enable),
	.low_power_mode_enable(low_power_mode_enable),
	.sar_powered(sar_powered), .conv_complete(conv_complete),
	.busy(busy));

// File: sim/test_adc_accumulator_burst_power_ctrl.sv
// Purpose: Self-checking bench for the converter accumulator control.
// Assumes: The bench plays both software and the SAR core.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`include "adcb_map.vh"

module test_adc_accumulator_burst_power_ctrl;
	logic        clk = 0;
	logic        srst = 1;
	logic [7:0]  sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata, rv;
	logic        sfr_wr = 0, sfr_rd = 0, soc_pulse = 0, complete_clear = 0;
	logic        converter_enable = 0, burst_mode_enable = 0, conv_done = 0;
	logic [11:0] conv_data = 0;
	logic        conv_start, twelve_bit_enable, low_power_mode_enable;
	logic        sar_powered, conv_complete, busy;
	logic [15:0] acc;
	int          fail_count = 0, checked = 0, n;

	adcb_ctrl u_adcb_ctrl (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
		.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.converter_enable(converter_enable),
		.burst_mode_enable(burst_mode_enable), .soc_pulse(soc_pulse),
		.complete_clear(complete_clear), .conv_done(conv_done),
		.conv_data(conv_data), .conv_start(conv_start),
		.twelve_bit_enable(twelve_bit_enable),
		.low_power_mode_enable(low_power_mode_enable),
		.sar_powered(sar_powered), .conv_complete(conv_complete),
		.busy(busy));

	// 25 MHz system clock.
	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [15:0] exp, got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_sim;
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input logic [7:0] pg, ad, d);
		@(posedge clk);
		#1 {sfr_page, sfr_addr, sfr_wdata, sfr_wr} = {pg, ad, d, 1'b1};
		@(posedge clk);
		#1 sfr_wr = 0;
	endtask
	// Read data is registered, so it is picked up a cycle later.
	task rd(input logic [7:0] pg, ad);
		@(posedge clk);
		#1 {sfr_page, sfr_addr, sfr_rd} = {pg, ad, 1'b1};
		@(posedge clk);
		#1 sfr_rd = 0;
		@(posedge clk);
		#1 rv = sfr_rdata;
	endtask
	task rres;
		rd(8'h00, 8'hBE);
		acc[15:8] = rv;
		rd(8'h00, 8'hBD);
		acc[7:0] = rv;
	endtask
	task pulse_soc;
		@(posedge clk);
		#1 soc_pulse = 1;
		@(posedge clk);
		#1 soc_pulse = 0;
	endtask
	// Plays the SAR core: waits for a start, returns one sample.
	task sample(input logic [11:0] d);
		n = 0;
		while (conv_start !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1 {conv_done, conv_data} = {1'b1, d};
		@(posedge clk);
		#1 conv_done = 0;
	endtask
	task finish_conv;
		for (int i = 0; i < 50 && conv_complete !== 1'b1; i++)
			@(posedge clk) #1;
		chk("complete set", 1, conv_complete);
		complete_clear = 1;
		@(posedge clk);
		#1 complete_clear = 0;
		@(posedge clk);
		#1 chk("complete cleared", 0, conv_complete);
	endtask
	task conv(input logic [11:0] d);
		pulse_soc;
		sample(d);
		finish_conv;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rd(8'h00, 8'hBA);
		chk("cfg reset", 16'h0000, rv);
		rd(8'h0F, 8'hBA);
		chk("power reset", 16'h000F, rv);
		rres;
		chk("result reset", 16'h0000, acc);
		wr(8'h00, 8'hBA, 8'hFF);
		rd(8'h00, 8'hBA);
		chk("cfg write-only and reserved", 16'h0080, rv);
		chk("twelve-bit on", 1, twelve_bit_enable);
		wr(8'h0F, 8'hBA, 8'hF3);
		rd(8'h0F, 8'hBA);
		chk("power unused bits", 16'h0083, rv);
		chk("low power on", 1, low_power_mode_enable);
		wr(8'h0F, 8'hBA, 8'h03);
		wr(8'h00, 8'hBA, 8'h00);
		chk("low power off", 0, low_power_mode_enable);
		chk("twelve-bit off", 0, twelve_bit_enable);
	endtask
	task t_single;
		converter_enable = 1;
		conv(12'h123);
		conv(12'h045);
		rres;
		chk("overwrite", 16'h0045, acc);
		chk("powered by enable", 1, sar_powered);
		wr(8'h00, 8'hBA, 8'h40);
		wr(8'h00, 8'hBE, 8'h00);
		wr(8'h00, 8'hBD, 8'h00);
		conv(12'h100);
		conv(12'h0FF);
		rres;
		chk("running sum", 16'h01FF, acc);
		wr(8'h00, 8'hBE, 8'h00);
		wr(8'h00, 8'hBD, 8'h00);
		conv(12'h007);
		rres;
		chk("sum restart", 16'h0007, acc);
	endtask
	task t_format;
		wr(8'h00, 8'hBE, 8'h12);
		wr(8'h00, 8'hBD, 8'h34);
		for (int s = 0; s < 5; s++)
		begin
			wr(8'h00, 8'hBA, {2'b10, s[2:0], 3'b000});
			rres;
			chk("format", s < 4 ? 16'h1234 >> s : 16'h2340, acc);
		end
		// Ten-bit left justify moves bit 9 up to bit 15.
		wr(8'h00, 8'hBA, 8'h20);
		rres;
		chk("format ten-bit left", 16'h8D00, acc);
		wr(8'h00, 8'hBA, 8'h00);
	endtask
	task t_idle;
		converter_enable = 0;
		pulse_soc;
		repeat (4) @(posedge clk);
		#1 chk("disabled start ignored", 0, busy);
		chk("unpowered", 0, sar_powered);
	endtask
	task t_burst;
		converter_enable = 1;
		burst_mode_enable = 1;
		for (int r = 0; r < 6; r++)
		begin
			wr(8'h00, 8'hBA, {5'b00000, r[2:0]});
			pulse_soc;
			repeat (r == 0 ? 1 : 2 << r) sample(12'h010);
			finish_conv;
			rres;
			chk("burst sum", (r == 0 ? 1 : 2 << r) * 16, acc);
			chk("stays powered", 1, sar_powered);
		end
		wr(8'h00, 8'hBA, 8'h00);
	endtask
	task t_lowpow;
		converter_enable = 0;
		for (int f = 0; f < 5; f += 4)
		begin
			wr(8'h0F, 8'hBA, f[7:0]);
			pulse_soc;
			sample(12'h0AB);
			chk("power-up delay", 1, n >= (f + 1) * `ADCB_PWR_STEP_CYC - 1
				&& n <= (f + 1) * `ADCB_PWR_STEP_CYC + 3);
			finish_conv;
			repeat (3) @(posedge clk);
			#1 chk("sleeps after burst", 0, sar_powered);
		end
	endtask
	// Reset in the middle of a power-up wait must leave all idle.
	task t_reset;
		wr(8'h00, 8'hBA, 8'h80);
		pulse_soc;
		srst = 1;
		repeat (2) @(posedge clk);
		#1 srst = 0;
		chk("busy after reset", 0, busy);
		@(posedge clk);
		#1 chk("unpowered after reset", 0, sar_powered);
		rd(8'h00, 8'hBA);
		chk("cfg after reset", 16'h0000, rv);
		rd(8'h0F, 8'hBA);
		chk("power after reset", 16'h000F, rv);
	endtask

	// Main sequence after five reset cycles.
	initial
	begin
		repeat (5) @(posedge clk);
		#1 srst = 0;
		t_regs;
		t_single;
		t_format;
		t_idle;
		t_burst;
		t_lowpow;
		t_reset;
		end_sim;
	end

	// Watchdog well beyond the several hundred cycles the run needs.
	initial
	begin
		#(40 * 20000);
		fail_count++;
		end_sim;
	end
endmodule // test_adc_accumulator_burst_power_ctrl

// File: src/adcb_ctrl.v
// Purpose: Accumulator configuration, burst sequencing and power-up
//          control for a successive-approximation converter.
// Assumes: SFR bus, SAR handshake and loose control bits all run on clk.
// Notes:   Reads return data one cycle after sfr_rd; unmapped reads 0x00.
`timescale 1ns/10ps
`include "adcb_map.vh"

module adcb_ctrl
(
	// Clock and reset
	input  wire        clk,
	input  wire        srst,
	// SFR access
	input  wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_page,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_wdata,
	output reg  [7:0]  sfr_rdata,
	// Loose control bits
	input  wire        converter_enable,
	input  wire        burst_mode_enable,
	input  wire        soc_pulse,
	input  wire        complete_clear,
	// SAR core handshake
	input  wire        conv_done,
	input  wire [11:0] conv_data,
	output reg         conv_start,
	// Converter mode and status
	output reg         twelve_bit_enable,
	output reg         low_power_mode_enable,
	output reg         sar_powered,
	output reg         conv_complete,
	output reg         busy
);

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	localparam ST_IDLE  = 2'b00;
	localparam ST_PWRUP = 2'b01;
	localparam ST_CONV  = 2'b10;
	localparam ST_WAIT  = 2'b11;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Burst length from the repeat code; reserved codes behave as zero.
	function [6:0] rpt_len;
		input [2:0] code;
		begin
			case (code)
				3'h0: rpt_len = 7'd1;
				3'h1: rpt_len = 7'd4;
				3'h2: rpt_len = 7'd8;
				3'h3: rpt_len = 7'd16;
				3'h4: rpt_len = 7'd32;
				3'h5: rpt_len = 7'd64;
				default: rpt_len = 7'd1;
			endcase
		end
	endfunction

	// True when the bus addresses a given register.
	function hit;
		input [7:0] addr;
		input [7:0] page;
		input [7:0] want_addr;
		input [7:0] want_page;
		begin
			hit = (addr == want_addr) && (page == want_page);
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg        accum_reg;
	reg [2:0]  sjst_reg;
	reg [2:0]  rpt_reg;
	reg [3:0]  pwr_field_reg;
	reg [15:0] acc_reg;
	reg [15:0] acc_next;
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [6:0]  left_reg;
	reg [6:0]  left_next;
	reg        first_reg;
	reg        first_next;
	reg        burst_reg;
	reg        burst_next;
	reg        start_next;
	reg        pwr_start;
	reg        set_complete;
	reg [7:0]  rd_next;

	wire [15:0] fmt_word;
	wire        pwr_done;
	wire        wr_cfg;
	wire        wr_pwr;
	wire        wr_high;
	wire        wr_low;
	wire [15:0] sample;

	assign sample  = {4'h0, conv_data};
	assign wr_cfg  = sfr_wr && hit(sfr_addr, sfr_page,
		`ADCB_ADDR_ACC_CFG, `ADCB_PAGE_ACC_CFG);
	assign wr_pwr  = sfr_wr && hit(sfr_addr, sfr_page,
		`ADCB_ADDR_PWR_TIME, `ADCB_PAGE_PWR_TIME);
	assign wr_high = sfr_wr && hit(sfr_addr, sfr_page,
		`ADCB_ADDR_RES_HIGH, `ADCB_PAGE_RESULT);
	assign wr_low  = sfr_wr && hit(sfr_addr, sfr_page,
		`ADCB_ADDR_RES_LOW, `ADCB_PAGE_RESULT);

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	adcb_fmt u_fmt
	(
		.acc        (acc_reg),
		.sjst       (sjst_reg),
		.twelve_bit (twelve_bit_enable),
		.fmt_word   (fmt_word)
	);

	adcb_pwr_timer #(.STEP_CYC(`ADCB_PWR_STEP_CYC)) u_pwr
	(
		.clk   (clk),
		.srst  (srst),
		.start (pwr_start),
		.field (pwr_field_reg),
		.done  (pwr_done)
	);

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	// Only the implemented bits are stored, so unused bits cannot leak.
	always @(posedge clk)
	begin
		if (srst)
		begin
			twelve_bit_enable     <= `ADCB_CFG_TWELVE_RST;
			accum_reg             <= 1'b0;
			sjst_reg              <= 3'h0;
			rpt_reg               <= 3'h0;
			low_power_mode_enable <= 1'b0;
			pwr_field_reg         <= `ADCB_PWR_FIELD_RST;
		end
		else
		begin
			if (wr_cfg)
			begin
				// [R01] twelve-bit select
				twelve_bit_enable <= sfr_wdata[`ADCB_CFG_TWELVE_BIT];
				accum_reg         <= sfr_wdata[`ADCB_CFG_ACCUM];
				// [R18] reserved format fallback
				sjst_reg <= (sfr_wdata[5:3] > `ADCB_SJST_LEFT) ?
					3'h0 : sfr_wdata[5:3];
				// [R18] reserved repeat fallback
				rpt_reg <= (sfr_wdata[2:0] > `ADCB_RPT_MAX) ?
					3'h0 : sfr_wdata[2:0];
			end
			if (wr_pwr)
			begin
				// [R09] low power select
				low_power_mode_enable <= sfr_wdata[`ADCB_PWR_LPM];
				// [R10] bits 6:4 dropped
				pwr_field_reg <= sfr_wdata[3:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Sequencer and accumulator next state
	// ------------------------------------------------------------------
	// A start event is ignored while a conversion or burst is running.
	always @*
	begin
		state_next   = state_reg;
		left_next    = left_reg;
		first_next   = first_reg;
		burst_next   = burst_reg;
		acc_next     = acc_reg;
		start_next   = 1'b0;
		pwr_start    = 1'b0;
		set_complete = 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (soc_pulse && burst_mode_enable)
				begin
					// [R07] burst length
					left_next  = rpt_len(rpt_reg);
					first_next = 1'b1;
					burst_next = 1'b1;
					if (converter_enable)
					begin
						// [R12] immediate start
						start_next = 1'b1;
						state_next = ST_CONV;
					end
					else
					begin
						// [R13] wait power-up
						pwr_start  = 1'b1;
						state_next = ST_PWRUP;
					end
				end
				else if (soc_pulse && converter_enable)
				begin
					left_next  = 7'd1;
					burst_next = 1'b0;
					start_next = 1'b1;
					state_next = ST_CONV;
				end
			end
			ST_PWRUP:
			begin
				// [R14] delay elapsed
				if (pwr_done)
				begin
					start_next = 1'b1;
					state_next = ST_CONV;
				end
			end
			ST_CONV:
			begin
				if (conv_done)
				begin
					if (burst_reg)
					begin
						// Burst sums start fresh each burst.
						acc_next   = first_reg ? sample :
							acc_reg + sample;
						first_next = 1'b0;
					end
					// [R02] running sum
					else if (accum_reg)
						acc_next = acc_reg + sample;
					// [R03] newest result
					else
						acc_next = sample;
					left_next = left_reg - 7'd1;
					state_next = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (left_reg == 7'd0)
				begin
					// [R16] set on finish
					set_complete = 1'b1;
					state_next   = ST_IDLE;
				end
				else
				begin
					start_next = 1'b1;
					state_next = ST_CONV;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
		// [R17] byte load
		// [R04] zero restarts sum
		if (wr_high)
			acc_next = {sfr_wdata, acc_next[7:0]};
		if (wr_low)
			acc_next = {acc_next[15:8], sfr_wdata};
	end

	// ------------------------------------------------------------------
	// Sequencer registers and status outputs
	// ------------------------------------------------------------------
	always @(posedge clk)
	begin
		if (srst)
		begin
			state_reg     <= ST_IDLE;
			left_reg      <= 7'd0;
			first_reg     <= 1'b0;
			burst_reg     <= 1'b0;
			acc_reg       <= 16'h0000;
			conv_start    <= 1'b0;
			conv_complete <= 1'b0;
			sar_powered   <= 1'b0;
			busy          <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			left_reg   <= left_next;
			first_reg  <= first_next;
			burst_reg  <= burst_next;
			acc_reg    <= acc_next;
			conv_start <= start_next;
			busy       <= (state_next != ST_IDLE);
			// [R16] set beats clear
			if (set_complete)
				conv_complete <= 1'b1;
			else if (complete_clear)
				conv_complete <= 1'b0;
			// [R11] enable-only power
			if (!burst_mode_enable)
				sar_powered <= converter_enable;
			// [R13] sleep between bursts
			else
				sar_powered <= converter_enable ||
					(state_next == ST_CONV) ||
					(state_next == ST_WAIT) ||
					(state_next == ST_PWRUP);
		end
	end

	// ------------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------------
	// Unmapped addresses answer zero so software never sees stale data.
	always @*
	begin
		rd_next = 8'h00;
		if (hit(sfr_addr, sfr_page, `ADCB_ADDR_ACC_CFG,
			`ADCB_PAGE_ACC_CFG))
			// [R05] write-only bit reads zero
			rd_next = {twelve_bit_enable, 1'b0, sjst_reg, rpt_reg};
		else if (hit(sfr_addr, sfr_page, `ADCB_ADDR_PWR_TIME,
			`ADCB_PAGE_PWR_TIME))
			// [R10] unused bits zero
			rd_next = {low_power_mode_enable, 3'h0, pwr_field_reg};
		else if (hit(sfr_addr, sfr_page, `ADCB_ADDR_RES_HIGH,
			`ADCB_PAGE_RESULT))
			// [R06] formatted high byte
			rd_next = fmt_word[15:8];
		else if (hit(sfr_addr, sfr_page, `ADCB_ADDR_RES_LOW,
			`ADCB_PAGE_RESULT))
			rd_next = fmt_word[7:0];
	end

	// Read data holds until the next read strobe.
	always @(posedge clk)
	begin
		if (srst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= rd_next;
	end

endmodule // adcb_ctrl

// File: src/adcb_fmt.v
// Purpose: Formats the accumulator for read-back (shift and justify).
// Assumes: Combinational; the caller registers the byte it returns.
// Notes:   Reserved format codes fall back to plain right justify.
`timescale 1ns/10ps
`include "adcb_map.vh"

module adcb_fmt
(
	// Accumulator and format selection
	input  wire [15:0] acc,
	input  wire [2:0]  sjst,
	input  wire        twelve_bit,
	// Formatted word
	output reg  [15:0] fmt_word
);

	// ------------------------------------------------------------------
	// Shift and justify
	// ------------------------------------------------------------------
	// Left justify moves the sample's top bit to bit 15.
	// [R06] format select
	// [R18] reserved format fallback
	always @*
	begin
		case (sjst)
			3'h0: fmt_word = acc;
			3'h1: fmt_word = acc >> 1;
			3'h2: fmt_word = acc >> 2;
			3'h3: fmt_word = acc >> 3;
			`ADCB_SJST_LEFT:
				fmt_word = twelve_bit ? (acc << 4) : (acc << 6);
			default: fmt_word = acc;
		endcase
	end

endmodule // adcb_fmt

// File: src/adcb_map.vh
// Purpose: Register map, field positions, reset values and timing counts
//          for the converter accumulator, burst and power-up control.
// Assumes: Registers are reached by SFR address plus SFR page.
// Notes:   Definitions only; included by bare name.
//
// What this block does
// [R01] Bit 7 selects twelve-bit converter mode.
// [R02] Accumulate bit sums results outside burst mode.
// [R03] Without accumulate, newest result overwrites pair.
// [R04] Writing zero to both bytes restarts sum.
// [R05] Accumulate bit is write-only, reads zero.
// [R06] Format field gives shift or left justify.
// [R07] Repeat field sets burst length 1..64.
// [R08] Software keeps repeat zero outside burst mode.
// [R09] Power register bit 7 selects low power.
// [R10] Power register bits 6:4 read zero.
// [R11] Outside burst, power follows main enable only.
// [R12] Burst with enable stays powered, starts immediately.
// [R13] Burst without enable sleeps, waits power-up delay.
// [R14] Delay is field plus one times 400 ns.
// [R15] Software should program power-up field to four.
// [R16] Complete flag set per conversion or burst.
// [R17] Result bytes load accumulator halves on write.
// [R18] Reserved format or repeat codes act as zero.
`ifndef ADCB_MAP_VH
`define ADCB_MAP_VH

// ----------------------------------------------------------------------
// Register addresses and pages
// ----------------------------------------------------------------------
`define ADCB_ADDR_ACC_CFG   8'hBA
`define ADCB_PAGE_ACC_CFG   8'h00
`define ADCB_ADDR_PWR_TIME  8'hBA
`define ADCB_PAGE_PWR_TIME  8'h0F
`define ADCB_ADDR_RES_HIGH  8'hBE
`define ADCB_ADDR_RES_LOW   8'hBD
`define ADCB_PAGE_RESULT    8'h00

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ADCB_CFG_TWELVE_BIT 7
`define ADCB_CFG_ACCUM      6
`define ADCB_CFG_SJST_HI    5
`define ADCB_CFG_SJST_LO    3
`define ADCB_CFG_RPT_HI     2
`define ADCB_CFG_RPT_LO     0
`define ADCB_PWR_LPM        7
`define ADCB_PWR_FIELD_HI   3
`define ADCB_PWR_FIELD_LO   0
`define ADCB_ACC_CFG_RESET  8'h00
`define ADCB_PWR_TIME_RESET 8'h0F
`define ADCB_CFG_TWELVE_RST 1'b0
`define ADCB_PWR_FIELD_RST  4'hF
`define ADCB_SJST_LEFT      3'h4
`define ADCB_RPT_MAX        3'h5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ADCB_CLK_PERIOD_NS  40
`define ADCB_PWR_STEP_NS    400
`define ADCB_PWR_STEP_CYC   (`ADCB_PWR_STEP_NS / `ADCB_CLK_PERIOD_NS)

`endif

// File: src/adcb_pwr_timer.v
// Purpose: Counts the burst power-up delay, (field + 1) steps of 400 ns.
// Assumes: start is a one-cycle pulse; field is stable while counting.
// Notes:   done pulses one cycle when the full delay has elapsed.
`timescale 1ns/10ps
`include "adcb_map.vh"

module adcb_pwr_timer
#(
	parameter STEP_CYC = `ADCB_PWR_STEP_CYC
)
(
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	// Control
	input  wire       start,
	input  wire [3:0] field,
	// Status
	output reg        done
);

	reg [8:0] count_reg;
	reg       run_reg;

	// ------------------------------------------------------------------
	// Down counter
	// ------------------------------------------------------------------
	// Loaded with the whole delay so a least time is never cut short.
	// [R14] delay length
	always @(posedge clk)
	begin
		if (srst)
		begin
			count_reg <= 9'h000;
			run_reg   <= 1'b0;
			done      <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				count_reg <= ({5'h00, field} + 9'h001)
					* STEP_CYC[8:0] - 9'h001;
				run_reg   <= 1'b1;
			end
			else if (run_reg)
			begin
				if (count_reg == 9'h000)
				begin
					run_reg <= 1'b0;
					done    <= 1'b1;
				end
				else
					count_reg <= count_reg - 9'h001;
			end
		end
	end

endmodule // adcb_pwr_timer
